// ---- src/isl_device.sv ----
// Sensor end: supply reset, access delay, host port and image store
//
// Design decisions made here: the register offsets and the plain strobed port.
module isl_device #(
  parameter int ACCESS_CYC = isl_pkg::ACCESS_CYC,
  parameter int TB_CYC     = isl_pkg::TB_CYC
) (
  // Clock and reset
  input  logic             ref_clk,
  input  logic             sys_rst,
  // Supply monitors
  input  logic             vdd_ok,
  input  logic             vddio_ok,
  // Host link
  isl_link_if.dev          link,
  // Status
  output logic             dev_ready,
  output logic             dev_spi_mode,
  output logic             dev_adv_save,
  output isl_pkg::isl_pwr_e dev_power_state,
  output logic [3:0]       dev_load_msg
);
  import isl_pkg::*;

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] csb_r, sck_r, mosi_r, vdd_r, vio_r;
  logic       csb_p, sck_p;

  // Two stages on every outside input
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      csb_r  <= 2'h3;
      sck_r  <= 2'h0;
      mosi_r <= 2'h0;
      vdd_r  <= 2'h0;
      vio_r  <= 2'h0;
      csb_p  <= 1'b1;
      sck_p  <= 1'b0;
    end else begin
      csb_r  <= {csb_r[0], link.csb};
      sck_r  <= {sck_r[0], link.sck};
      mosi_r <= {mosi_r[0], link.mosi};
      vdd_r  <= {vdd_r[0], vdd_ok};
      vio_r  <= {vio_r[0], vddio_ok};
      csb_p  <= csb_r[1];
      sck_p  <= sck_r[1];
    end
  end

  logic sup_lost, rise, fall, sel, ready_q;
  assign sup_lost = !(vdd_r[1] && vio_r[1]);
  assign rise     = sck_r[1] && !sck_p;
  assign fall     = !sck_r[1] && sck_p;
  assign sel      = !csb_r[1] && ready_q;

  // --------------------------------------------------------------------------
  // Access delay and timebase
  // --------------------------------------------------------------------------
  logic [23:0] acc_q, tbd_q;
  logic [7:0]  tb_q;

  // Registers open a fixed delay after both supplies are good
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q   <= 24'h0;
      ready_q <= 1'b0;
    end else if (sup_lost) begin
      acc_q   <= 24'h0;
      ready_q <= 1'b0;
    end else if (!ready_q) begin
      if (acc_q == 24'(ACCESS_CYC - 1)) ready_q <= 1'b1;
      else acc_q <= acc_q + 24'h1;
    end
  end

  // Free-running sensor time, low byte
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tbd_q <= 24'h0;
      tb_q  <= 8'h0;
    end else if (sup_lost) begin
      tbd_q <= 24'h0;
      tb_q  <= 8'h0;
    end else if (tbd_q == 24'(TB_CYC - 1)) begin
      tbd_q <= 24'h0;
      tb_q  <= tb_q + 8'h1;
    end else begin
      tbd_q <= tbd_q + 24'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Serial slave and registers
  // --------------------------------------------------------------------------
  logic [2:0]  bit_q;
  logic [7:0]  sh_q, tx_q, ctrl_q, b, rd_data;
  logic [6:0]  addr_q, rd_addr;
  logic [3:0]  ofs_lo_q, msg_q;
  logic [7:0]  ofs_hi_q;
  logic [12:0] ptr_q;
  logic        hdr_q, rd_q, miso_q, oe_q, spi_q, aps_q, loaded_q, load_go_q, soft_q;
  logic        byte_done, img_we;
  logic [7:0]  img_q [0:IMG_BYTES-1];
  isl_pwr_e    pwr_q;

  assign b         = {sh_q[6:0], mosi_r[1]};
  assign byte_done = sel && rise && (bit_q == 3'h7);
  assign rd_addr   = hdr_q ? b[6:0] : addr_q;
  assign img_we    = byte_done && !hdr_q && !rd_q && (addr_q == REG_INIT_DATA);

  // Read value of the register being fetched
  always_comb begin
    case (rd_addr)
      REG_PART_ID:   rd_data = PART_ID_VAL;
      REG_TIMEBASE:  rd_data = tb_q;
      REG_STATUS:    rd_data = {4'h0, msg_q};
      REG_INIT_CTRL: rd_data = ctrl_q;
      REG_OFS_LO:    rd_data = {4'h0, ofs_lo_q};
      REG_OFS_HI:    rd_data = ofs_hi_q;
      REG_INIT_DATA: rd_data = img_q[ptr_q];
      REG_PWR_CFG:   rd_data = {7'h0, aps_q};
      default:       rd_data = 8'h00;
    endcase
  end

  // Frame decode, register writes, read shifting
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_q <= 3'h0; sh_q <= 8'h0; tx_q <= 8'h0; addr_q <= 7'h0; hdr_q <= 1'b1; rd_q <= 1'b0;
      miso_q <= 1'b0; oe_q <= 1'b0; spi_q <= 1'b0; aps_q <= APS_RST; ctrl_q <= 8'h0;
      ofs_lo_q <= 4'h0; ofs_hi_q <= 8'h0; ptr_q <= 13'h0; loaded_q <= 1'b0;
      load_go_q <= 1'b0; soft_q <= 1'b0;
    end else if (sup_lost || soft_q) begin
      if (sup_lost) spi_q <= 1'b0;
      aps_q <= APS_RST;
      bit_q <= 3'h0; hdr_q <= 1'b1; oe_q <= 1'b0; ctrl_q <= 8'h0; ofs_lo_q <= 4'h0;
      ofs_hi_q <= 8'h0; ptr_q <= 13'h0; loaded_q <= 1'b0; load_go_q <= 1'b0; soft_q <= 1'b0;
    end else begin
      load_go_q <= 1'b0;
      oe_q      <= sel;
      if (!sel) begin
        bit_q <= 3'h0;
        hdr_q <= 1'b1;
        if (csb_r[1] && !csb_p && ready_q) spi_q <= 1'b1;
      end else if (rise) begin
        sh_q  <= b;
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          if (hdr_q) begin
            hdr_q  <= 1'b0;
            rd_q   <= b[7];
            addr_q <= b[6:0];
          end
          if (hdr_q && b[7] && spi_q) begin
            tx_q <= 8'h00;
          end else if (hdr_q ? b[7] : rd_q) begin
            tx_q <= rd_data;
            if (rd_addr == REG_INIT_DATA) ptr_q <= ptr_q + 13'h1;
            else addr_q <= rd_addr + 7'h1;
          end else if (!hdr_q) begin
            if (addr_q == REG_INIT_DATA) ptr_q <= ptr_q + 13'h1;
            else addr_q <= addr_q + 7'h1;
            case (addr_q)
              REG_PWR_CFG: aps_q <= b[0];
              REG_INIT_CTRL: begin
                ctrl_q <= b;
                if (b == LOAD_DONE && !loaded_q) begin
                  load_go_q <= 1'b1;
                  loaded_q  <= 1'b1;
                end
              end
              REG_OFS_LO: begin
                ofs_lo_q <= b[3:0];
                ptr_q    <= {ofs_hi_q, b[3:0], 1'b0};
              end
              REG_OFS_HI: begin
                ofs_hi_q <= b;
                ptr_q    <= {b, ofs_lo_q, 1'b0};
              end
              REG_COMMAND: soft_q <= (b == CMD_SOFT_RST);
              default: ;
            endcase
          end
        end
      end else if (fall) begin
        miso_q <= tx_q[7];
        tx_q   <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // Image store, bytes land in sequence
  always_ff @(posedge ref_clk) begin
    if (img_we) img_q[ptr_q] <= b;
  end

  // --------------------------------------------------------------------------
  // Configuration load completion
  // --------------------------------------------------------------------------
  logic [11:0] ld_q;
  logic        ld_busy_q;

  // Suspend until the load is checked, then configuration mode
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ld_q <= 12'h0; ld_busy_q <= 1'b0; msg_q <= MSG_IDLE; pwr_q <= ISL_SUSPEND;
    end else if (sup_lost || soft_q) begin
      ld_q <= 12'h0; ld_busy_q <= 1'b0; msg_q <= MSG_IDLE; pwr_q <= ISL_SUSPEND;
    end else if (load_go_q) begin
      ld_q      <= 12'h0;
      ld_busy_q <= 1'b1;
    end else if (ld_busy_q) begin
      if (ld_q == 12'(LOAD_CYC - 1)) begin
        ld_busy_q <= 1'b0;
        msg_q     <= MSG_OK;
        pwr_q     <= ISL_CONFIG;
      end else begin
        ld_q <= ld_q + 12'h1;
      end
    end
  end

  assign link.miso_o     = miso_q;
  assign link.miso_oe    = oe_q;
  assign dev_ready       = ready_q;
  assign dev_spi_mode    = spi_q;
  assign dev_adv_save    = aps_q;
  assign dev_power_state = pwr_q;
  assign dev_load_msg    = msg_q;

endmodule : isl_device

// ---- src/isl_host.sv ----
// Host end: start-up and configuration image upload sequencer
// Operation
// - Reads: no dummy on I2C, one on SPI
// - Port starts I2C; first dummy read selects SPI
// - Host first reads and checks the part identifier
// - Advanced power saving is on after any reset
// - Either supply dropping low resets the device
// - No register access until 450 us after supplies
// - Sensor stays suspended until initialization completes
// - After the identifier check, host clears advanced power saving
// - Host then waits 450 us before continuing
// - Host writes 0x00 to load control first
// - Host burst-writes 8 kB image; device stores sequentially
// - Device returns stored image on data port reads
// - Between chunks, offsets advance by bytes over two
// - Host writes 0x01 to load control afterwards
// - Load-completion write at most once per reset
// - Result code 0b0001 within 20 ms; host polls
// - Successful load switches device to configuration mode
// - With power saving on, writes 450 us apart
module isl_host #(
  parameter int ACCESS_CYC   = isl_pkg::ACCESS_CYC,
  parameter int LOAD_MAX_CYC = isl_pkg::LOAD_MAX_CYC
) (
  // Clock and reset
  input  logic        ref_clk,
  input  logic        sys_rst,
  // Software register port
  input  logic [3:0]  hst_addr,
  input  logic [7:0]  hst_wdata,
  input  logic        hst_wr,
  input  logic        hst_rd,
  output logic [7:0]  hst_rdata,
  // Image source
  output logic [12:0] img_addr,
  input  logic [7:0]  img_byte,
  // Sensor link
  isl_link_if.host    link
);
  import isl_pkg::*;

  // --------------------------------------------------------------------------
  // Link engine
  // --------------------------------------------------------------------------
  logic [1:0]  miso_r;
  logic [3:0]  div_q;
  logic [2:0]  bit_q;
  logic [8:0]  left_q, nb_q;
  logic [7:0]  tx_q, rx_q, hdr_q, wd_q, nxt;
  logic [12:0] img_addr_q;
  logic        busy_q, csb_q, sck_q, mosi_q, done_q, go_q, src_q;

  assign nxt = src_q ? img_byte : wd_q;

  // Data-in synchroniser
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) miso_r <= 2'h3;
    else miso_r <= {miso_r[0], link.miso};
  end

  // Clock divider, frame and bit shifting (mode 0, MSB first)
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 4'h0; bit_q <= 3'h0; left_q <= 9'h0; tx_q <= 8'h0; rx_q <= 8'h0;
      busy_q <= 1'b0; csb_q <= 1'b1; sck_q <= 1'b0; mosi_q <= 1'b0; done_q <= 1'b0;
      img_addr_q <= 13'h0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        div_q <= 4'h0;
        if (go_q) begin
          busy_q <= 1'b1;
          csb_q  <= 1'b0;
          bit_q  <= 3'h0;
          left_q <= nb_q;
          mosi_q <= hdr_q[7];
          tx_q   <= {hdr_q[6:0], 1'b0};
        end
      end else if (div_q != SCK_HALF - 4'h1) begin
        div_q <= div_q + 4'h1;
      end else begin
        div_q <= 4'h0;
        if (!sck_q) begin
          sck_q <= 1'b1;
          rx_q  <= {rx_q[6:0], miso_r[1]};
        end else begin
          sck_q <= 1'b0;
          bit_q <= bit_q + 3'h1;
          if (bit_q != 3'h7) begin
            mosi_q <= tx_q[7];
            tx_q   <= {tx_q[6:0], 1'b0};
          end else if (left_q == 9'h0) begin
            busy_q <= 1'b0;
            csb_q  <= 1'b1;
            done_q <= 1'b1;
          end else begin
            left_q <= left_q - 9'h1;
            mosi_q <= nxt[7];
            tx_q   <= {nxt[6:0], 1'b0};
            if (src_q) img_addr_q <= img_addr_q + 13'h1;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  isl_hst_e    st_q;
  logic [7:0]  id_q, exp_q;
  logic        start_q, running;

  assign running = (st_q != HS_IDLE) && (st_q != HS_OK) && (st_q != HS_FAIL);

  // Writes and one-cycle-late reads
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      exp_q     <= PART_ID_VAL;
      start_q   <= 1'b0;
      hst_rdata <= 8'h00;
    end else begin
      start_q <= hst_wr && (hst_addr == HREG_CTRL) && hst_wdata[0];
      if (hst_wr && hst_addr == HREG_EXP) exp_q <= hst_wdata;
      if (hst_rd) begin
        case (hst_addr)
          HREG_CTRL: hst_rdata <= 8'h00;
          HREG_STAT: hst_rdata <= {5'h0, st_q == HS_FAIL, st_q == HS_OK, running};
          HREG_ID:   hst_rdata <= id_q;
          HREG_EXP:  hst_rdata <= exp_q;
          default:   hst_rdata <= 8'h00;
        endcase
      end else begin
        hst_rdata <= 8'h00;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Wait timer
  // --------------------------------------------------------------------------
  logic [22:0] tmr_q;
  logic        wait_q, tmr_clr;

  // Restarts at idle, after the save-off write, and after each image chunk
  assign tmr_clr = (st_q == HS_IDLE) || (wait_q && done_q && st_q == HS_APS) || (!wait_q && st_q == HS_NEXT);

  // Saturating cycle counter
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) tmr_q <= 23'h0;
    else if (tmr_clr) tmr_q <= 23'h0;
    else if (tmr_q != 23'h7fffff) tmr_q <= tmr_q + 23'h1;
  end

  // --------------------------------------------------------------------------
  // Start-up sequencer
  // --------------------------------------------------------------------------
  logic [12:0] word_q;
  logic [12:0] word_nx;

  assign word_nx = word_q + 13'(CHUNK_BYTES >> 1);

  // Launch one link transfer and wait for its end
  task automatic issue(input logic rd, input logic [6:0] ra, input logic [8:0] nb,
                       input logic [7:0] wd, input logic src);
    go_q   <= 1'b1;
    wait_q <= 1'b1;
    hdr_q  <= {rd, ra};
    nb_q   <= nb;
    wd_q   <= wd;
    src_q  <= src;
  endtask : issue

  // One step per state, each after the previous transfer ends
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= HS_IDLE; go_q <= 1'b0; wait_q <= 1'b0; hdr_q <= 8'h0; nb_q <= 9'h0;
      wd_q <= 8'h0; src_q <= 1'b0; word_q <= 13'h0; id_q <= 8'h0;
    end else begin
      go_q <= 1'b0;
      if (wait_q) begin
        if (done_q) wait_q <= 1'b0;
      end else begin
        unique case (st_q)
          HS_IDLE: if (start_q) st_q <= HS_PWRUP;
          HS_PWRUP: if (tmr_q >= 23'(ACCESS_CYC)) begin
            issue(1'b1, REG_PART_ID, DUMMY_I2C + 9'h1, 8'h00, 1'b0);
            st_q <= HS_DUMMY;
          end
          HS_DUMMY: begin
            issue(1'b1, REG_PART_ID, DUMMY_SPI + 9'h1, 8'h00, 1'b0);
            st_q <= HS_ID;
          end
          HS_ID: begin
            id_q <= rx_q;
            if (rx_q == exp_q) begin
              issue(1'b0, REG_PWR_CFG, 9'h1, 8'h00, 1'b0);
              st_q <= HS_APS;
            end else begin
              st_q <= HS_FAIL;
            end
          end
          HS_APS: if (tmr_q >= 23'(ACCESS_CYC)) begin
            issue(1'b0, REG_INIT_CTRL, 9'h1, LOAD_PREP, 1'b0);
            word_q <= 13'h0;
            st_q   <= HS_OFS_LO;
          end
          HS_OFS_LO: begin
            issue(1'b0, REG_OFS_LO, 9'h1, {4'h0, word_q[3:0]}, 1'b0);
            st_q <= HS_OFS_HI;
          end
          HS_OFS_HI: begin
            issue(1'b0, REG_OFS_HI, 9'h1, word_q[11:4], 1'b0);
            st_q <= HS_CHUNK;
          end
          HS_CHUNK: begin
            issue(1'b0, REG_INIT_DATA, CHUNK_BYTES, 8'h00, 1'b1);
            st_q <= HS_NEXT;
          end
          HS_NEXT: begin
            word_q <= word_nx;
            if (word_nx == 13'(IMG_BYTES / 2)) begin
              issue(1'b0, REG_INIT_CTRL, 9'h1, LOAD_DONE, 1'b0);
              st_q <= HS_POLL;
            end else begin
              st_q <= HS_OFS_LO;
            end
          end
          HS_POLL: begin
            issue(1'b1, REG_STATUS, DUMMY_SPI + 9'h1, 8'h00, 1'b0);
            st_q <= HS_CHECK;
          end
          HS_CHECK: begin
            if (rx_q[3:0] == MSG_OK) st_q <= HS_OK;
            else if (tmr_q >= 23'(LOAD_MAX_CYC)) st_q <= HS_FAIL;
            else st_q <= HS_POLL;
          end
          HS_OK, HS_FAIL: ;
          default: st_q <= HS_IDLE;
        endcase
      end
    end
  end

  assign link.csb  = csb_q;
  assign link.sck  = sck_q;
  assign link.mosi = mosi_q;
  assign img_addr  = img_addr_q;

endmodule : isl_host

// ---- src/isl_link_if.sv ----
// Serial host link between the controller and the sensor
interface isl_link_if;
  logic csb;
  logic sck;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // Pulled-up data-out line
  assign miso = miso_oe ? miso_o : 1'b1;

  modport host (output csb, output sck, output mosi, input miso);
  modport dev  (input csb, input sck, input mosi, output miso_o, output miso_oe);
endinterface : isl_link_if

// ---- src/isl_pkg.sv ----
// Shared constants and types of the start-up configuration loader
package isl_pkg;

  // --------------------------------------------------------------------------
  // Device register map (7-bit register addresses)
  // --------------------------------------------------------------------------
  localparam logic [6:0] REG_PART_ID   = 7'h00;
  localparam logic [6:0] REG_TIMEBASE  = 7'h18;
  localparam logic [6:0] REG_STATUS    = 7'h21;
  localparam logic [6:0] REG_INIT_CTRL = 7'h59;
  localparam logic [6:0] REG_OFS_LO    = 7'h5b;
  localparam logic [6:0] REG_OFS_HI    = 7'h5c;
  localparam logic [6:0] REG_INIT_DATA = 7'h5e;
  localparam logic [6:0] REG_PWR_CFG   = 7'h7c;
  localparam logic [6:0] REG_COMMAND   = 7'h7e;

  // --------------------------------------------------------------------------
  // Field values and reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] PART_ID_VAL  = 8'h5a;  // Arbitrary identifier value
  localparam logic [7:0] CMD_SOFT_RST = 8'hb6;
  localparam logic [7:0] LOAD_PREP    = 8'h00;
  localparam logic [7:0] LOAD_DONE    = 8'h01;
  localparam logic [3:0] MSG_IDLE     = 4'h0;
  localparam logic [3:0] MSG_OK       = 4'h1;
  localparam logic       APS_RST      = 1'b1;
  localparam logic [8:0] DUMMY_I2C    = 9'h000;
  localparam logic [8:0] DUMMY_SPI    = 9'h001;
  localparam int         IMG_BYTES    = 8192;
  localparam logic [8:0] CHUNK_BYTES  = 9'h100;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int         CLK_MHZ      = 250;
  localparam int         ACCESS_US    = 450;
  localparam int         LOAD_MAX_US  = 20000;
  localparam int         ACCESS_CYC   = ACCESS_US * CLK_MHZ;
  localparam int         LOAD_MAX_CYC = LOAD_MAX_US * CLK_MHZ;
  localparam int         LOAD_CYC     = 1000;    // Device image check time
  localparam int         TB_CYC       = 9766;    // One timebase step
  localparam logic [3:0] SCK_HALF     = 4'h8;    // Link clock half period

  // --------------------------------------------------------------------------
  // Host controller registers
  // --------------------------------------------------------------------------
  localparam logic [3:0] HREG_CTRL    = 4'h0;
  localparam logic [3:0] HREG_STAT    = 4'h1;
  localparam logic [3:0] HREG_ID      = 4'h2;
  localparam logic [3:0] HREG_EXP     = 4'h3;

  typedef enum logic {ISL_SUSPEND = 1'b0, ISL_CONFIG = 1'b1} isl_pwr_e;

  typedef enum logic [3:0] {
    HS_IDLE  = 4'h0, HS_PWRUP  = 4'h1, HS_DUMMY = 4'h2, HS_ID    = 4'h3,
    HS_APS   = 4'h4, HS_OFS_LO = 4'h5, HS_OFS_HI = 4'h6, HS_CHUNK = 4'h7,
    HS_NEXT  = 4'h8, HS_POLL   = 4'h9, HS_CHECK = 4'ha, HS_OK    = 4'hb,
    HS_FAIL  = 4'hc
  } isl_hst_e;

endpackage : isl_pkg

// ---- verification/isl_link_checker.sv ----
// Link-side assertions of the start-up loader
module isl_link_checker import isl_pkg::*; #(
  parameter int ACCESS_CYC = 200
) (
  // Clock and reset
  input logic ref_clk,
  input logic sys_rst,
  // Link wires
  input logic csb,
  input logic sck,
  input logic mosi,
  input logic miso_o,
  input logic miso_oe,
  input logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  localparam int GAP_MIN = ACCESS_CYC - 2;  // Edge alignment slack
  logic [15:0] up_q;   // Cycles since reset
  logic [15:0] gap_q;  // Cycles deselected
  logic [3:0]  nb_q;   // Header bits seen
  logic [7:0]  hdr_q;  // Frame header
  logic        pwr_q;  // Last frame wrote power config
  // Uptime and gap counters
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) up_q <= '0;
    else if (up_q != 16'hffff) up_q <= up_q + 16'h1;
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) gap_q <= '0;
    else if (!csb) gap_q <= '0;
    else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h1;
  end
  // Header capture on link clock rises
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nb_q  <= '0;
      hdr_q <= '0;
    end else if (csb) nb_q <= '0;
    else if ($rose(sck) && nb_q < 4'h8) begin
      nb_q  <= nb_q + 4'h1;
      hdr_q <= {hdr_q[6:0], mosi};
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) pwr_q <= 1'b0;
    else if ($rose(csb)) pwr_q <= (hdr_q == {1'b0, REG_PWR_CFG});
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_sck_idle_low: assert property (csb |-> !sck) else $error("sck high while deselected");
  a_sck_high_len: assert property ($rose(sck) |-> sck [*8] ##1 !sck) else $error("sck high phase");
  a_sck_low_len: assert property ($fell(sck) && !csb |-> !sck [*8]) else $error("sck low phase");
  a_frame_gap: assert property ($rose(csb) |-> csb [*3]) else $error("frame gap short");
  a_first_access: assert property ($fell(csb) |-> up_q >= 16'(GAP_MIN)) else $error("early frame");
  a_oe_ready: assert property (miso_oe |-> up_q >= 16'(GAP_MIN)) else $error("early drive");
  a_oe_release: assert property ($rose(csb) |-> ##4 !miso_oe) else $error("miso not released");
  a_miso_hold: assert property ($rose(sck) && miso_oe |-> $stable(miso_o) ##1 $stable(miso_o))
    else $error("miso moved at sample");
  a_pull_up: assert property (!miso_oe |-> miso) else $error("released line not high");
  a_pwr_gap: assert property ($fell(csb) && pwr_q |-> gap_q >= 16'(GAP_MIN)) else $error("gap short");
  c_pwr_write: cover property ($rose(csb) ##1 pwr_q);
  c_dev_drive: cover property ($rose(miso_oe));
  c_burst: cover property (nb_q == 4'h8 && hdr_q == {1'b0, REG_INIT_DATA});
endmodule : isl_link_checker

// ---- verification/tb_top.sv ----
// Bench joining the host and device ends over the link
module tb_top import isl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and ends
  // ----------------------------------------------------------------
  localparam int ACC = 200;
  logic        ref_clk, sys_rst, vdd_ok, vddio_ok, hst_wr, hst_rd;
  logic        dev_ready, dev_spi_mode, dev_adv_save;
  logic [3:0]  hst_addr, dev_load_msg;
  logic [7:0]  hst_wdata, hst_rdata, img_byte, rv, seed;
  logic [12:0] img_addr, prev_addr;
  isl_pwr_e    dev_power_state;
  int          fails, checked;
  isl_link_if isl_link_if_inst ();
  isl_host #(.ACCESS_CYC(ACC), .LOAD_MAX_CYC(20000)) isl_host_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .hst_addr(hst_addr), .hst_wdata(hst_wdata), .hst_wr(hst_wr), .hst_rd(hst_rd), .hst_rdata(hst_rdata),
    .img_addr(img_addr), .img_byte(img_byte), .link(isl_link_if_inst.host));
  isl_device #(.ACCESS_CYC(ACC), .TB_CYC(50)) isl_device_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .vdd_ok(vdd_ok), .vddio_ok(vddio_ok), .link(isl_link_if_inst.dev), .dev_ready(dev_ready),
    .dev_spi_mode(dev_spi_mode), .dev_adv_save(dev_adv_save), .dev_power_state(dev_power_state),
    .dev_load_msg(dev_load_msg));
  isl_link_checker #(.ACCESS_CYC(ACC)) isl_link_checker_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .csb(isl_link_if_inst.csb), .sck(isl_link_if_inst.sck), .mosi(isl_link_if_inst.mosi),
    .miso_o(isl_link_if_inst.miso_o), .miso_oe(isl_link_if_inst.miso_oe), .miso(isl_link_if_inst.miso));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [7:0] bad_id(input logic [7:0] s);
    return PART_ID_VAL ^ (s | 8'h01);  // Never the true identifier
  endfunction : bad_id
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic bound_ok(input logic ok);
    chk(ok, 1'b1);
    if (ok !== 1'b1) test_done();
  endtask : bound_ok
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    hst_addr  <= a;
    hst_wdata <= d;
    hst_wr    <= 1'b1;
    @(posedge ref_clk);
    hst_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    hst_addr <= a;
    hst_rd   <= 1'b1;
    @(posedge ref_clk);
    hst_rd <= 1'b0;
    @(posedge ref_clk);
    d = hst_rdata;
  endtask : rd
  task automatic wait_stat(input logic [7:0] m);
    for (int i = 0; i < 400; i++) begin
      rd(HREG_STAT, rv);
      if ((rv & m) != 8'h00) return;
      repeat (50) @(posedge ref_clk);
    end
    bound_ok(1'b0);
  endtask : wait_stat
  // Image source and fetch order monitor
  always @(posedge ref_clk) begin
    img_byte <= img_addr[7:0] ^ 8'h3c;
    if (!sys_rst && img_addr !== prev_addr) chk(16'(img_addr), 16'(prev_addr + 13'h1));
    prev_addr <= img_addr;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {sys_rst, vdd_ok, vddio_ok, hst_wr, hst_rd} = 5'b11100;
    {hst_addr, hst_wdata} = '0;
    {fails, checked, seed} = {32'h0, 32'h0, 8'h1e};
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk(dev_adv_save, APS_RST);
    chk(dev_power_state, ISL_SUSPEND);
    repeat (ACC - 20) @(posedge ref_clk);
    chk(dev_ready, 1'b0);
    repeat (30) @(posedge ref_clk);
    chk(dev_ready, 1'b1);
    rd(HREG_EXP, rv);
    chk(rv, PART_ID_VAL);
    rd(HREG_CTRL, rv);
    chk(rv, 8'h00);
    // Unmapped addresses read zero
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      rd((seed[3:2] == 2'b00) ? {2'b01, seed[1:0]} : seed[3:0], rv);
      chk(rv, 8'h00);
    end
    // Wrong expected identifier ends in failure
    seed = lfsr(seed);
    wr(HREG_EXP, bad_id(seed));
    wr(HREG_CTRL, 8'h01);
    wait_stat(8'h06);
    chk(rv[2:0], 3'b100);
    rd(HREG_ID, rv);
    chk(rv, PART_ID_VAL);
    chk(dev_spi_mode, 1'b1);
    chk(dev_adv_save, APS_RST);
    wr(HREG_CTRL, 8'h01);
    rd(HREG_STAT, rv);
    chk(rv[2:0], 3'b100);
    // Second reset, then upload under way
    sys_rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk(dev_spi_mode, 1'b0);
    wr(HREG_CTRL, 8'h01);
    for (int i = 0; i < 30000 && img_addr < 13'd40; i++) @(posedge ref_clk);
    bound_ok(img_addr >= 13'd40);
    chk(dev_adv_save, 1'b0);
    chk(dev_power_state, ISL_SUSPEND);
    chk(dev_load_msg, MSG_IDLE);
    rd(HREG_STAT, rv);
    chk(rv[2:0], 3'b001);
    for (int i = 0; i < 32; i++) chk(isl_device_inst.img_q[i], 16'(8'(i) ^ 8'h3c));
    // Either supply dropping resets the device
    for (int s = 0; s < 2; s++) begin
      if (s == 0) vddio_ok <= 1'b0;
      else vdd_ok <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk({dev_ready, dev_spi_mode, dev_adv_save, dev_power_state}, 4'b0010);
      vdd_ok   <= 1'b1;
      vddio_ok <= 1'b1;
      for (int i = 0; i < 3 * ACC && dev_ready !== 1'b1; i++) @(posedge ref_clk);
      bound_ok(dev_ready);
    end
    test_done();
  end
endmodule : tb_top
